/* design/pfr_arb_end.sv */
// arbitration end: fault modes, fault queue, return insertion, rescheduling
`timescale 1ns/100ps
`default_nettype none
module pfr_arb_end #(
   parameter int TW    = pfr_pkg::TAG_W,
   parameter int SW    = pfr_pkg::SLICE_W,
   parameter int CW    = pfr_pkg::CLIENT_W,
   parameter int DW    = pfr_pkg::DATA_W,
   parameter int DEPTH = pfr_pkg::FQ_DEPTH
) (
   input  wire logic          clk,
   input  wire logic          rst,
   pfr_link_if.dev            link,
   input  wire logic          legacyMode,    // context runs fault-and-hang
   input  wire logic          faultHaltAll,  // force every fault to halt
   input  wire logic          legacyResume,  // ignore legacy fault, go on
   input  wire logic          walkValid,     // translation result
   input  wire logic          walkWrite,
   input  wire logic          walkDataPort,  // data port tlb path, else via l3
   input  wire logic [1:0]    walkFault,
   input  wire logic [TW-1:0] walkTag,
   input  wire logic [SW-1:0] walkSlice,
   input  wire logic [CW-1:0] walkClient,
   output logic               walkReady,
   output logic               memReqValid,   // access sent to memory
   output logic               memReqWrite,
   output logic [TW-1:0]      memReqTag,
   output logic               dpRspValid,    // data port walk response
   output logic [1:0]         dpRspFault,
   output logic               legacyIrq,     // pulse on legacy hang
   output logic               legacyHang,
   output logic               pageReqValid,  // page request queue entry
   output logic               pageReqLast,
   output logic [1:0]         pageReqFault,
   input  wire logic          pageRspValid,
   input  wire logic          pageRspLast,
   output logic               missBlock,
   input  wire logic          switchReq,     // scheduler preempt
   input  wire logic          streamOnFault, // context type, same path
   output logic               switchDone,
   output logic               ctxPending
);
   localparam int EW = TW + SW + CW + DW + 2;  // return buffer entry
   localparam int PW = $clog2(DEPTH);
   localparam int NW = $clog2(DEPTH + 1);

   pfr_pkg::pfr_mode_t mode;  // run / halt / hang
   pfr_pkg::pfr_mode_t next_mode;
   logic [TW+SW+CW+2-1:0] fq [DEPTH];  // fault entries, no data kept
   logic [PW-1:0] fqWr;               // write pointer
   logic [PW-1:0] fqRd;               // read pointer
   logic [NW-1:0] fqCnt;              // occupancy
   logic [NW-1:0] next_fqCnt;
   logic [EW-1:0] buf0;               // two-entry return buffer
   logic [EW-1:0] buf1;
   logic          bVal0;
   logic          bVal1;
   logic          next_bVal1;
   logic          room;               // registered buffer space
   logic [4:0]    bubbleTmr;          // rearm timer for bubble pulses
   logic [7:0]    pendFaults;         // halt faults awaiting response
   logic          swPend;             // switch-out waiting
   logic          termPend;           // pending switch is a termination
   logic          waitLast;           // marker sent, awaiting its answer

   // decode of the walk result
   wire accept    = walkValid & walkReady;
   wire faulted   = accept & (walkFault != pfr_pkg::FC_NONE);
   wire haltMode  = faultHaltAll | ~legacyMode;
   wire faultHalt = faulted & haltMode;
   wire faultHang = faulted & ~haltMode;
   wire fqPush    = faulted & ~walkWrite;  // faulted reads only
   // queue drains only into idle slots of the main return
   wire fqPop     = ~link.rbValid & room & (fqCnt != '0);
   wire rbTake    = link.rbValid & room;
   wire bPush     = rbTake | fqPop;
   wire bPop      = bVal0 & link.retReady;
   wire [TW+SW+CW+2-1:0] fqHead = fq[fqRd];
   // faulted return: all fields valid, data zeroed as undefined
   wire [EW-1:0] bIn = rbTake ?
      {link.rbTag, link.rbSlice, link.rbClient, link.rbData, pfr_pkg::FC_NONE} :
      {fqHead[TW+SW+CW+1:2], {DW{1'b0}}, fqHead[1:0]};
   wire rspOk     = pageRspValid & ~pageRspLast;
   wire lastOk    = pageRspValid & pageRspLast & waitLast;
   // no switch while a halt fault is unserviced
   wire swGo      = swPend & (mode != pfr_pkg::PFR_HALT) & ~faultHalt;

   // mode transitions
   always_comb begin
      next_mode = mode;
      case (mode)
         pfr_pkg::PFR_RUN: begin
            if (faultHalt)
               next_mode = pfr_pkg::PFR_HALT;  // stall on fault
            else if (faultHang)
               next_mode = pfr_pkg::PFR_HANG;
         end
         pfr_pkg::PFR_HALT: begin
            if (pageRspValid)
               next_mode = pfr_pkg::PFR_RUN;  // software serviced it
         end
         pfr_pkg::PFR_HANG: begin
            if (legacyResume)
               next_mode = pfr_pkg::PFR_RUN;
         end
         default: next_mode = pfr_pkg::PFR_RUN;
      endcase
   end

   // occupancy after this cycle
   assign next_fqCnt = fqCnt + NW'(fqPush) - NW'(fqPop);
   assign next_bVal1 = bPop ? (bVal1 & bPush) : (bVal1 | (bPush & bVal0));

   // mode and walk handshake; full queue stalls every walk
   always_ff @(posedge clk) begin
      if (rst) begin
         mode      <= pfr_pkg::PFR_RUN;
         walkReady <= 1'b0;
      end else begin
         mode      <= next_mode;
         walkReady <= (next_mode == pfr_pkg::PFR_RUN) && (next_fqCnt < NW'(DEPTH));
      end
   end

   // legacy reporting and miss blocking
   always_ff @(posedge clk) begin
      if (rst) begin
         legacyIrq  <= 1'b0;
         legacyHang <= 1'b0;
         missBlock  <= 1'b0;
      end else begin
         legacyIrq  <= faultHang;
         legacyHang <= (next_mode == pfr_pkg::PFR_HANG);
         // hits run on elsewhere; only misses are held
         missBlock  <= (next_mode == pfr_pkg::PFR_HALT);
      end
   end

   // memory issue and data port responses
   always_ff @(posedge clk) begin
      if (rst) begin
         memReqValid     <= 1'b0;
         memReqWrite     <= 1'b0;
         memReqTag       <= '0;
         dpRspValid      <= 1'b0;
         dpRspFault      <= pfr_pkg::FC_NONE;
         link.wrRspValid <= 1'b0;
         link.wrRspTag   <= '0;
         link.wrRspFault <= pfr_pkg::FC_NONE;
      end else begin
         memReqValid     <= accept & ~faulted;
         memReqWrite     <= walkWrite;
         memReqTag       <= walkTag;
         dpRspValid      <= accept & walkDataPort;
         dpRspFault      <= walkFault;
         link.wrRspValid <= accept & walkDataPort & walkWrite;
         link.wrRspTag   <= walkTag;
         link.wrRspFault <= walkFault;
      end
   end

   // fault response queue storage, one write port
   always_ff @(posedge clk) begin
      if (fqPush)
         fq[fqWr] <= {walkTag, walkSlice, walkClient, walkFault};
   end

   // queue pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         fqWr  <= '0;
         fqRd  <= '0;
         fqCnt <= '0;
      end else begin
         fqWr  <= fqPush ? PW'(fqWr + 1'b1) : fqWr;
         fqRd  <= fqPop ? PW'(fqRd + 1'b1) : fqRd;
         fqCnt <= next_fqCnt;
      end
   end

   // bubble pulses while responses wait; rearm after the far window
   // interception of stolen-memory returns is not used here
   // the bubble scheme keeps faulted reads off the memory entirely
   always_ff @(posedge clk) begin
      if (rst) begin
         bubbleTmr      <= '0;
         link.bubbleReq <= 1'b0;
      end else if (bubbleTmr != '0) begin
         bubbleTmr      <= bubbleTmr - 5'h1;
         link.bubbleReq <= 1'b0;
      end else begin
         link.bubbleReq <= (fqCnt != '0);
         bubbleTmr      <= (fqCnt != '0) ? 5'(pfr_pkg::BUBBLE_WINDOW) : 5'h0;
      end
   end

   // two-entry return buffer; stall reaches the return bus via rbReady
   always_ff @(posedge clk) begin
      if (rst) begin
         bVal0 <= 1'b0;
         bVal1 <= 1'b0;
         room  <= 1'b0;
         buf0  <= '0;
         buf1  <= '0;
      end else begin
         room  <= ~next_bVal1;
         bVal1 <= next_bVal1;
         if (bPop) begin
            bVal0 <= bVal1 | bPush;
            buf0  <= bVal1 ? buf1 : bIn;
            if (bVal1 && bPush)
               buf1 <= bIn;
         end else if (bPush) begin
            bVal0 <= 1'b1;
            if (!bVal0)
               buf0 <= bIn;
            else
               buf1 <= bIn;
         end
      end
   end

   // return fields, fault code only toward l3
   assign link.rbReady   = room;
   assign link.retValid  = bVal0;
   assign {link.retTag, link.retSlice, link.retClient, link.retData, link.retFault} = buf0;

   // page requests, switch-out and rescheduling
   always_ff @(posedge clk) begin
      if (rst) begin
         pageReqValid       <= 1'b0;
         pageReqLast        <= 1'b0;
         pageReqFault       <= pfr_pkg::FC_NONE;
         pendFaults         <= '0;
         swPend             <= 1'b0;
         termPend           <= 1'b0;
         waitLast           <= 1'b0;
         switchDone         <= 1'b0;
         ctxPending         <= 1'b0;
         link.schedNotify   <= 1'b0;
         link.schedSwitchOk <= 1'b0;
      end else begin
         pageReqValid       <= faultHalt | (swGo & (pendFaults != '0));
         pageReqLast        <= ~faultHalt;
         pageReqFault       <= walkFault;
         switchDone         <= swGo;
         link.schedNotify   <= lastOk;
         link.schedSwitchOk <= swGo & termPend & (pendFaults == '0);
         // intermediate answers ignored while the marker waits
         if (lastOk)
            pendFaults <= '0;
         else if (faultHalt)
            pendFaults <= pendFaults + 8'h1;
         else if (rspOk && !waitLast && pendFaults != '0)
            pendFaults <= pendFaults - 8'h1;
         // termination and preempt latch; set wins over completion
         if (swGo) begin
            swPend   <= link.terminate | switchReq;
            termPend <= link.terminate;
         end else if (link.terminate || switchReq) begin
            swPend   <= 1'b1;
            termPend <= termPend | link.terminate;
         end
         // stream-on-fault contexts follow the same marker path
         if (swGo && pendFaults != '0) begin
            waitLast   <= 1'b1;
            ctxPending <= 1'b1;
         end else if (lastOk) begin
            waitLast   <= 1'b0;
            ctxPending <= 1'b0;
         end
      end
   end

   // stream-on-fault needs no separate handling in this path
   wire unusedStream = streamOnFault;
endmodule : pfr_arb_end
`default_nettype wire

/* design/pfr_far_end.sv */
// far end: return bus source with bubbles, l3 fault handling, scheduler pools
`timescale 1ns/100ps
`default_nettype none
module pfr_far_end #(
   parameter int TW = pfr_pkg::TAG_W,
   parameter int SW = pfr_pkg::SLICE_W,
   parameter int CW = pfr_pkg::CLIENT_W,
   parameter int DW = pfr_pkg::DATA_W
) (
   input  wire logic          clk,
   input  wire logic          rst,
   pfr_link_if.far            link,
   input  wire logic          srcValid,   // memory read returns
   input  wire logic [TW-1:0] srcTag,
   input  wire logic [SW-1:0] srcSlice,
   input  wire logic [CW-1:0] srcClient,
   input  wire logic [DW-1:0] srcData,
   output logic               srcReady,
   output logic               cliValid,   // toward sampler / icache
   output logic [TW-1:0]      cliTag,
   output logic [CW-1:0]      cliClient,
   output logic [DW-1:0]      cliData,
   output logic [1:0]         cliFault,
   input  wire logic          cliReady,
   output logic               l3Fill,     // line filled into l3
   input  wire logic          terminateReq,
   output logic               ctxAvailable,
   output logic               ctxPendPool,
   output logic               termDone
);
   logic bubbleDue;  // idle slot owed to the arbitration end

   // advance when the slot is empty or taken
   wire advance = ~link.rbValid | link.rbReady;
   wire l3Take  = link.retValid & link.retReady;
   wire faulty  = link.retFault != pfr_pkg::FC_NONE;

   // source ready follows the slot, held off for the owed bubble
   assign srcReady     = advance & ~bubbleDue;
   assign link.retReady = ~cliValid | cliReady;

   // return bus stage; bubble comes two clocks after the pulse when the slot is not stalled
   always_ff @(posedge clk) begin
      if (rst) begin
         bubbleDue      <= 1'b0;
         link.rbValid   <= 1'b0;
         link.rbTag     <= '0;
         link.rbSlice   <= '0;
         link.rbClient  <= '0;
         link.rbData    <= '0;
      end else begin
         if (advance && bubbleDue) begin
            bubbleDue     <= link.bubbleReq;
            link.rbValid  <= 1'b0;  // the idle slot
         end else begin
            bubbleDue <= bubbleDue | link.bubbleReq;
            if (advance) begin
               link.rbValid   <= srcValid;
               link.rbTag     <= srcTag;
               link.rbSlice   <= srcSlice;
               link.rbClient  <= srcClient;
               link.rbData    <= srcData;
            end
         end
      end
   end

   // l3: faulted lines are uncacheable and forwarded with code
   always_ff @(posedge clk) begin
      if (rst) begin
         cliValid  <= 1'b0;
         cliTag    <= '0;
         cliClient <= '0;
         cliData   <= '0;
         cliFault  <= pfr_pkg::FC_NONE;
         l3Fill    <= 1'b0;
      end else begin
         l3Fill <= l3Take & ~faulty;
         if (link.retReady) begin
            cliValid  <= link.retValid;
            cliTag    <= link.retTag;
            cliClient <= link.retClient;
            cliData   <= link.retData;
            cliFault  <= link.retFault;
         end
      end
   end

   // scheduler pools and termination handshake
   always_ff @(posedge clk) begin
      if (rst) begin
         link.terminate <= 1'b0;
         ctxAvailable   <= 1'b0;
         ctxPendPool    <= 1'b0;
         termDone       <= 1'b0;
      end else begin
         link.terminate <= terminateReq;
         termDone       <= link.schedSwitchOk | (link.schedNotify & ctxPendPool);
         if (link.schedNotify) begin
            ctxAvailable <= 1'b1;  // pending to available
            ctxPendPool  <= 1'b0;
         end else if (terminateReq) begin
            ctxAvailable <= 1'b0;
            ctxPendPool  <= 1'b1;
         end else if (link.schedSwitchOk) begin
            ctxPendPool  <= 1'b0;
         end
      end
   end
endmodule : pfr_far_end
`default_nettype wire

/* design/pfr_link_if.sv */
// link between the arbitration end and the return/l3/scheduler end
`timescale 1ns/100ps
`default_nettype none
interface pfr_link_if #(
   parameter int TW = pfr_pkg::TAG_W,
   parameter int SW = pfr_pkg::SLICE_W,
   parameter int CW = pfr_pkg::CLIENT_W,
   parameter int DW = pfr_pkg::DATA_W
);
   // main read return from the return bus interface
   logic          rbValid;
   logic [TW-1:0] rbTag;
   logic [SW-1:0] rbSlice;
   logic [CW-1:0] rbClient;
   logic [DW-1:0] rbData;
   logic          rbReady;    // buffer room at the arbitration end
   logic          bubbleReq;  // one-cycle pulse asking for an idle slot
   // read return toward l3, with fault code
   logic          retValid;
   logic [TW-1:0] retTag;
   logic [SW-1:0] retSlice;
   logic [CW-1:0] retClient;
   logic [DW-1:0] retData;
   logic [1:0]    retFault;
   logic          retReady;
   // data port write response
   logic          wrRspValid;
   logic [TW-1:0] wrRspTag;
   logic [1:0]    wrRspFault;
   // scheduler events
   logic          schedNotify;   // last fault answered
   logic          schedSwitchOk; // clean switch-out after termination
   logic          terminate;     // termination request pulse
   modport dev (
      input  rbValid, rbTag, rbSlice, rbClient, rbData, retReady, terminate,
      output rbReady, bubbleReq, retValid, retTag, retSlice, retClient, retData,
      output retFault, wrRspValid, wrRspTag, wrRspFault, schedNotify, schedSwitchOk
   );
   modport far (
      output rbValid, rbTag, rbSlice, rbClient, rbData, retReady, terminate,
      input  rbReady, bubbleReq, retValid, retTag, retSlice, retClient, retData,
      input  retFault, wrRspValid, wrRspTag, wrRspFault, schedNotify, schedSwitchOk
   );
endinterface : pfr_link_if
`default_nettype wire

/* design/pfr_pkg.sv */
// shared constants and types for the page-fault return path
package pfr_pkg;
   // fault codes on the two-bit field
   localparam logic [1:0] FC_NONE        = 2'h0;
   localparam logic [1:0] FC_NOT_PRESENT = 2'h1;
   localparam logic [1:0] FC_PRIVILEGE   = 2'h2;
   localparam logic [1:0] FC_WRITE_PERM  = 2'h3;
   // structure sizes
   localparam int FQ_DEPTH      = 16;  // fault response queue entries
   localparam int BUBBLE_WINDOW = 16;  // clocks the far end may take
   localparam int TAG_W         = 8;
   localparam int SLICE_W       = 2;
   localparam int CLIENT_W      = 4;
   localparam int DATA_W        = 64;
   // fault handling state, gray along run->halt->hang
   typedef enum logic [1:0] {
      PFR_RUN  = 2'b00,
      PFR_HALT = 2'b01,
      PFR_HANG = 2'b11
   } pfr_mode_t;
endpackage : pfr_pkg

/* sim/pfr_chk.sv */
// link-side assertions for the page-fault return path
`timescale 1ns/100ps
`default_nettype none
module pfr_chk (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic                        rbValid,
   input wire logic                        bubbleReq,
   input wire logic                        retValid,
   input wire logic                        retReady,
   input wire logic [pfr_pkg::TAG_W-1:0]   retTag,
   input wire logic [pfr_pkg::DATA_W-1:0]  retData,
   input wire logic [1:0]                  retFault,
   input wire logic                        schedNotify,
   input wire logic                        schedSwitchOk,
   input wire logic                        terminate
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // a bubble request must open an idle return slot soon
   property p_bubble_gap;
      bubbleReq |-> ##[0:16] !rbValid;
   endproperty
   a_bubble_gap: assert property (p_bubble_gap)
      else $error("no idle return slot after bubble request");

   // a stalled return keeps its tag, data and fault code
   property p_ret_hold;
      retValid && !retReady |=> retValid && $stable(retTag) && $stable(retFault)
         && $stable(retData);
   endproperty
   a_ret_hold: assert property (p_ret_hold)
      else $error("return changed while stalled");

   // faulted return carries no memory data, zero by choice
   property p_fault_nodata;
      retValid && retFault != pfr_pkg::FC_NONE |-> retData == '0;
   endproperty
   a_fault_nodata: assert property (p_fault_nodata)
      else $error("faulted return carries data");

   // bubble requests are spaced, not held high
   property p_bubble_space;
      bubbleReq |=> !bubbleReq [*8];
   endproperty
   a_bubble_space: assert property (p_bubble_space)
      else $error("bubble requests too close");

   // scheduler notice is a single pulse
   property p_notify_pulse;
      schedNotify |=> !schedNotify;
   endproperty
   a_notify_pulse: assert property (p_notify_pulse)
      else $error("scheduler notice longer than one cycle");

   // clean switch-out report is a single pulse
   property p_ok_pulse;
      schedSwitchOk |=> !schedSwitchOk;
   endproperty
   a_ok_pulse: assert property (p_ok_pulse)
      else $error("switch-out report longer than one cycle");

   // a context is either held pending or reported clean, not both
   property p_ok_excl;
      !(schedSwitchOk && schedNotify);
   endproperty
   a_ok_excl: assert property (p_ok_excl)
      else $error("clean report and marker answer together");

   // termination always ends in a report; the bench answers quickly
   property p_term_done;
      terminate |-> ##[1:60] (schedSwitchOk || schedNotify);
   endproperty
   a_term_done: assert property (p_term_done)
      else $error("termination never reported");
endmodule : pfr_chk
`default_nettype wire

/* sim/pfr_tb_top.sv */
// bench joining the arbitration end and the far end over the link
`timescale 1ns/100ps
`default_nettype none
module pfr_tb_top;
   localparam int TW = pfr_pkg::TAG_W;
   logic          clk = 1'h0;  // 50 MHz
   logic          rst = 1'h1;
   logic          legacyMode = 1'h0, faultHaltAll = 1'h0, legacyResume = 1'h0;
   logic          walkValid = 1'h0, walkWrite = 1'h0, walkDataPort = 1'h0;
   logic [1:0]    walkFault = 2'h0;
   logic [TW-1:0] walkTag = '0;
   logic          pageRspValid = 1'h0, switchReq = 1'h0, terminateReq = 1'h0;
   logic          pageRspLast = 1'h0;  // marker flag on the page response
   logic          srcValid = 1'h0, cliReady = 1'h0, take;
   logic [63:0]   srcData = 64'h0, expData = 64'h0;
   logic          walkReady, memReqValid, memReqWrite, dpRspValid, legacyIrq, legacyHang;
   logic          pageReqValid, pageReqLast, missBlock, switchDone, ctxPending, srcReady;
   logic          cliValid, l3Fill, ctxAvailable, ctxPendPool, termDone;
   logic [1:0]    dpRspFault, pageReqFault, cliFault;
   logic [TW-1:0] memReqTag, cliTag;
   logic [3:0]    cliClient;
   logic [63:0]   cliData;
   int            failCount = 0, compares = 0, cyc = 0, faultRet = 0, bubbles = 0;
   int            switches = 0, n;
   // rows of {write, data port, fault code}
   logic [3:0]    rows [8] = '{4'h5, 4'h6, 4'h7, 4'h4, 4'hd, 4'hc, 4'h1, 4'h8};

   pfr_link_if link ();
   pfr_arb_end pfr_arb_end_i (.clk(clk), .rst(rst), .link(link), .legacyMode(legacyMode),
      .faultHaltAll(faultHaltAll), .legacyResume(legacyResume), .walkValid(walkValid),
      .walkWrite(walkWrite), .walkDataPort(walkDataPort), .walkFault(walkFault),
      .walkTag(walkTag), .walkSlice(walkTag[1:0]), .walkClient(walkTag[3:0]),
      .walkReady(walkReady), .memReqValid(memReqValid), .memReqWrite(memReqWrite),
      .memReqTag(memReqTag), .dpRspValid(dpRspValid), .dpRspFault(dpRspFault),
      .legacyIrq(legacyIrq), .legacyHang(legacyHang), .pageReqValid(pageReqValid),
      .pageReqLast(pageReqLast), .pageReqFault(pageReqFault), .pageRspValid(pageRspValid),
      .pageRspLast(pageRspLast), .missBlock(missBlock), .switchReq(switchReq),
      .streamOnFault(1'h0), .switchDone(switchDone), .ctxPending(ctxPending));
   pfr_far_end pfr_far_end_i (.clk(clk), .rst(rst), .link(link), .srcValid(srcValid),
      .srcTag(srcData[TW-1:0]), .srcSlice(srcData[1:0]), .srcClient(srcData[3:0]),
      .srcData(srcData), .srcReady(srcReady), .cliValid(cliValid), .cliTag(cliTag),
      .cliClient(cliClient), .cliData(cliData), .cliFault(cliFault), .cliReady(cliReady),
      .l3Fill(l3Fill), .terminateReq(terminateReq), .ctxAvailable(ctxAvailable),
      .ctxPendPool(ctxPendPool), .termDone(termDone));
   pfr_chk pfr_chk_i (.clk(clk), .rst(rst), .rbValid(link.rbValid),
      .bubbleReq(link.bubbleReq), .retValid(link.retValid), .retReady(link.retReady),
      .retTag(link.retTag), .retData(link.retData), .retFault(link.retFault),
      .schedNotify(link.schedNotify), .schedSwitchOk(link.schedSwitchOk),
      .terminate(link.terminate));

   always #10 clk = ~clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         failCount++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reportAndStop();
      if (failCount == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : reportAndStop

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   // hold the walk until it is taken, return one cycle after
   task automatic issue(input logic w, input logic dp, input logic [1:0] f);
      walkWrite = w;
      walkDataPort = dp;
      walkFault = f;
      walkTag++;
      walkValid = 1'h1;
      for (n = 0; n < 50 && walkReady !== 1'h1; n++) tick();
      tick();
      walkValid = 1'h0;
   endtask : issue

   // service a halt fault and see the pipe reopen
   task automatic answer();
      check(missBlock, 1'h1);
      tick();
      check(walkReady, 1'h0);
      pageRspValid = 1'h1;
      tick();
      pageRspValid = 1'h0;
      tick();
      tick();
      check(missBlock, 1'h0);
      check(walkReady, 1'h1);
   endtask : answer

   task automatic walkRow(input logic [3:0] r);
      issue(r[3], r[2], r[1:0]);
      check(memReqValid, r[1:0] == 2'h0);
      if (r[1:0] == 2'h0) check(memReqTag, walkTag);
      check(dpRspValid, r[2]);
      if (r[2]) check(dpRspFault, r[1:0]);
      check(link.wrRspValid, r[3] & r[2]);
      if (r[3] & r[2]) check(link.wrRspFault, r[1:0]);
      check(pageReqValid, r[1:0] != 2'h0);
      if (r[1:0] != 2'h0) answer();
      else tick();
   endtask : walkRow

   // endless return stream, so fault replies need bubbles; sink stalls
   always @(posedge clk) begin
      take = srcValid && srcReady;
      if (!rst && cliValid === 1'h1 && cliReady) begin
         if (cliFault !== 2'h0) faultRet++;
         else begin
            check(cliData, expData);
            expData++;
         end
      end
      bubbles += (link.bubbleReq === 1'h1);
      switches += (switchDone === 1'h1);
      #1;
      if (take) srcData++;
      srcValid = !rst;
      cliReady = (cyc % 4) != 0;
   end

   // ceiling far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         failCount++;
         reportAndStop();
      end
   end

   initial begin
      repeat (5) tick();
      check(walkReady, 1'h0);
      rst = 1'h0;
      tick();
      tick();
      check(walkReady, 1'h1);
      foreach (rows[i]) walkRow(rows[i]);
      for (n = 0; n < 300 && faultRet < 4; n++) tick();
      check(faultRet, 4);
      check(bubbles > 0, 1'h1);
      // legacy hang, then resume
      legacyMode = 1'h1;
      issue(1'h1, 1'h1, 2'h1);
      check(legacyIrq, 1'h1);
      check(pageReqValid, 1'h0);
      tick();
      check(legacyHang, 1'h1);
      check(walkReady, 1'h0);
      legacyResume = 1'h1;
      tick();
      legacyResume = 1'h0;
      tick();
      tick();
      check(legacyHang, 1'h0);
      check(walkReady, 1'h1);
      // forced halt overrides legacy
      faultHaltAll = 1'h1;
      issue(1'h1, 1'h1, 2'h2);
      check(pageReqValid, 1'h1);
      check(legacyIrq, 1'h0);
      answer();
      // termination with nothing outstanding, then a plain preempt
      terminateReq = 1'h1;
      tick();
      terminateReq = 1'h0;
      for (n = 0; n < 40 && link.schedSwitchOk !== 1'h1; n++) tick();
      check(link.schedSwitchOk, 1'h1);
      check(ctxPending, 1'h0);
      tick();
      check(switches, 1);
      check(termDone, 1'h1);
      switchReq = 1'h1;
      tick();
      switchReq = 1'h0;
      for (n = 0; n < 40 && switches < 2; n++) tick();
      check(switches, 2);
      check(ctxPending, 1'h0);
      // termination while halted waits, then takes the marker path
      issue(1'h1, 1'h1, 2'h1);
      terminateReq = 1'h1;
      tick();
      terminateReq = 1'h0;
      tick();
      tick();
      check(switches, 2);
      pageRspValid = 1'h1;
      pageRspLast = 1'h1;
      tick();
      pageRspValid = 1'h0;
      pageRspLast = 1'h0;
      tick();
      check(pageReqValid & pageReqLast, 1'h1);
      check(ctxPending, 1'h1);
      pageRspValid = 1'h1;
      tick();
      check(link.schedNotify, 1'h0);
      check(ctxPending, 1'h1);
      pageRspLast = 1'h1;
      tick();
      pageRspValid = 1'h0;
      pageRspLast = 1'h0;
      check(link.schedNotify, 1'h1);
      check(ctxPending, 1'h0);
      tick();
      check(ctxAvailable, 1'h1);
      check(ctxPendPool, 1'h0);
      check(termDone, 1'h1);
      check(switches, 3);
      reportAndStop();
   end
endmodule : pfr_tb_top
`default_nettype wire
